// File: core/sfb_pkg.sv
// sfb_pkg: constants shared by the discovery parameter rom and its lookup leaf.
// assumes nothing of its surroundings; imported by name only.
package sfb_pkg;

	// ----------------------------------------------------------------
	// parameter header and placement
	// ----------------------------------------------------------------
	localparam logic [7:0]  PARAM_ID      = 8'hA5;
	localparam logic [7:0]  PARAM_LEN     = 8'h88;
	localparam logic [15:0] BASIC_BASE    = 16'h1090;
	localparam logic [7:0]  IDX_ID        = 8'h00;
	localparam logic [7:0]  IDX_LEN       = 8'h01;
	localparam logic [7:0]  IDX_BASIC     = 8'h02;
	// first section is 18 double words after the two header bytes
	localparam logic [7:0]  SEC2_START    = 8'h4A;
	localparam logic [7:0]  FILL_BYTE     = 8'hFF;

	// ----------------------------------------------------------------
	// basic flash parameter bytes, relative to the parameter start
	// ----------------------------------------------------------------
	localparam logic [7:0]  IDX_B00       = 8'h02;
	localparam logic [7:0]  IDX_B01       = 8'h03;
	localparam logic [7:0]  IDX_B02       = 8'h04;
	localparam logic [7:0]  IDX_B03       = 8'h05;
	localparam logic [7:0]  IDX_B04       = 8'h06;
	localparam logic [7:0]  IDX_B05       = 8'h07;
	localparam logic [7:0]  IDX_B06       = 8'h08;
	localparam logic [7:0]  IDX_B07       = 8'h09;
	localparam logic [7:0]  IDX_B08       = 8'h0A;
	localparam logic [7:0]  IDX_B09       = 8'h0B;
	localparam logic [7:0]  IDX_B0A       = 8'h0C;
	localparam logic [7:0]  IDX_B0B       = 8'h0D;
	localparam logic [7:0]  VAL_B00       = 8'hE7;
	localparam logic [7:0]  VAL_B01       = 8'hFF;
	localparam logic [7:0]  VAL_B02_SDR   = 8'hB2;
	localparam logic [7:0]  VAL_B02_DDR   = 8'hBA;
	localparam logic [7:0]  VAL_B03       = 8'hFF;
	localparam logic [7:0]  VAL_DENS_LO   = 8'hFF;
	localparam logic [7:0]  VAL_DENS_HI   = 8'h1F;
	localparam logic [7:0]  VAL_QIO_CYC   = 8'h48;
	localparam logic [7:0]  VAL_QIO_OP    = 8'hEB;
	localparam logic [7:0]  VAL_QO_CYC    = 8'hFF;
	localparam logic [7:0]  VAL_QO_OP     = 8'hFF;

	// ----------------------------------------------------------------
	// apb register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0]  REG_PTR       = 8'h00;
	localparam logic [7:0]  REG_DATA      = 8'h04;
	localparam logic [7:0]  REG_WORD      = 8'h08;
	localparam logic [7:0]  REG_STATUS    = 8'h0C;
	localparam logic [7:0]  REG_INFO      = 8'h10;
	localparam logic [7:0]  RST_PTR       = 8'h00;
	localparam int          ST_DENIED     = 8;
	localparam int          ST_SEC2       = 9;
	localparam int          ST_PAST       = 10;
	localparam int          ST_DDR        = 11;
	localparam int          ST_ACTIVE     = 12;

	typedef enum logic {
		SFB_IDLE,
		SFB_STREAM
	} sfb_state_t;

endpackage

// File: core/sfb_rom.sv
// sfb_rom: combinational byte lookup of the discovery parameter.
// assumes an index relative to the parameter start; unfilled bytes read as fill.
`timescale 1ns/1ps
`default_nettype none

module sfb_rom #(
	parameter bit DDR_VARIANT = 1'b0
) (
	input  wire logic [7:0] idx,
	output logic      [7:0] data
);

	always_comb begin
		case (idx)
			sfb_pkg::IDX_ID:  data = sfb_pkg::PARAM_ID;
			sfb_pkg::IDX_LEN: data = sfb_pkg::PARAM_LEN;
			sfb_pkg::IDX_B00: data = sfb_pkg::VAL_B00;
			sfb_pkg::IDX_B01: data = sfb_pkg::VAL_B01;
			sfb_pkg::IDX_B02: data = DDR_VARIANT ? sfb_pkg::VAL_B02_DDR
			                                     : sfb_pkg::VAL_B02_SDR;
			sfb_pkg::IDX_B03: data = sfb_pkg::VAL_B03;
			sfb_pkg::IDX_B04: data = sfb_pkg::VAL_DENS_LO;
			sfb_pkg::IDX_B05: data = sfb_pkg::VAL_DENS_LO;
			sfb_pkg::IDX_B06: data = sfb_pkg::VAL_DENS_LO;
			sfb_pkg::IDX_B07: data = sfb_pkg::VAL_DENS_HI;
			sfb_pkg::IDX_B08: data = sfb_pkg::VAL_QIO_CYC;
			sfb_pkg::IDX_B09: data = sfb_pkg::VAL_QIO_OP;
			sfb_pkg::IDX_B0A: data = sfb_pkg::VAL_QO_CYC;
			sfb_pkg::IDX_B0B: data = sfb_pkg::VAL_QO_OP;
			// rest of section 1 and the sector map (from SEC2_START) are not held here
			default:          data = sfb_pkg::FILL_BYTE;
		endcase
	end

endmodule

`default_nettype wire

// File: core/sfb_param_rom.sv
// sfb_param_rom: read-only discovery parameter with an apb slave and a byte stream port.
// assumes one clock pclk, asynchronous active-low presetn, stream requests synchronous.
//
// Function
// - all discovery tables appear as one contiguous byte parameter.
// - sector map section follows directly after the fixed first section.
// - relative byte 00h returns parameter identifier A5h.
// - relative byte 01h returns following-byte count 88h.
// - first basic byte sits at relative 02h, discovery address 1090h.
// - basic byte 00h reads E7h.
// - basic byte 01h reads FFh, no 4-KB erase opcode.
// - basic byte 02h reads B2h, or BAh on the DDR variant.
// - basic byte 03h reads FFh, all bits unused.
// - basic bytes 04h to 07h give density 1FFFFFFFh, low byte first.
// - basic byte 08h reads 48h, quad I/O mode and dummy cycles.
// - basic byte 09h reads quad I/O opcode EBh.
// - basic bytes 0Ah and 0Bh read FFh, quad output unsupported.
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module sfb_param_rom #(
	parameter bit DDR_VARIANT = 1'b0
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        xfer_start,
	input  wire logic [7:0]  xfer_addr,
	input  wire logic        xfer_next,
	input  wire logic        xfer_end,
	output logic      [7:0]  xfer_data,
	output logic             xfer_busy
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0]          ptr;
		logic [31:0]         rdata;
		logic                denied;
		sfb_pkg::sfb_state_t st;
		logic [7:0]          s_ptr;
		logic [7:0]          s_data;
		logic [15:0]         s_count;
	} sfb_regs_t;

	sfb_regs_t  state_r;
	sfb_regs_t  state_nxt;

	// ----------------------------------------------------------------
	// byte lookups: four lanes for the word view, one for the stream
	// ----------------------------------------------------------------
	logic [7:0] lane_idx  [5];
	logic [7:0] lane_data [5];

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_lane
			assign lane_idx[g] = state_r.ptr + 8'(g);
		end
	endgenerate
	// a new stream starts at the host address, later bytes at the stream pointer
	assign lane_idx[4] = xfer_start ? xfer_addr : state_r.s_ptr;

	generate
		for (g = 0; g < 5; g++) begin : g_rom
			sfb_rom #(
				.DDR_VARIANT (DDR_VARIANT)
			) u_rom (
				.idx  (lane_idx[g]),
				.data (lane_data[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	logic        setup_ph;
	logic        access_ph;
	logic        hit;
	logic        ro_write;
	logic [31:0] rd_mux;
	logic [31:0] status_w;
	logic        in_sec2;
	logic        past_end;

	assign setup_ph  = psel && !penable;
	assign access_ph = psel && penable;
	assign in_sec2   = (state_r.ptr >= sfb_pkg::SEC2_START);
	// last byte of the parameter sits at LEN + 1
	assign past_end  = (state_r.ptr > (sfb_pkg::PARAM_LEN + 8'h01));

	always_comb begin
		status_w = 32'h0000_0000;
		status_w[7:0]                 = state_r.ptr;
		status_w[sfb_pkg::ST_DENIED]  = state_r.denied;
		status_w[sfb_pkg::ST_SEC2]    = in_sec2;
		status_w[sfb_pkg::ST_PAST]    = past_end;
		status_w[sfb_pkg::ST_DDR]     = DDR_VARIANT;
		status_w[sfb_pkg::ST_ACTIVE]  = (state_r.st == sfb_pkg::SFB_STREAM);
		status_w[31:16]               = state_r.s_count;
	end

	always_comb begin
		hit    = 1'b1;
		rd_mux = 32'h0000_0000;
		if (paddr == sfb_pkg::REG_PTR) begin
			rd_mux = {24'h00_0000, state_r.ptr};
		end else if (paddr == sfb_pkg::REG_DATA) begin
			rd_mux = {24'h00_0000, lane_data[0]};
		end else if (paddr == sfb_pkg::REG_WORD) begin
			// low byte first, as the table stores multi-byte fields
			rd_mux = {lane_data[3], lane_data[2], lane_data[1], lane_data[0]};
		end else if (paddr == sfb_pkg::REG_STATUS) begin
			rd_mux = status_w;
		end else if (paddr == sfb_pkg::REG_INFO) begin
			rd_mux = {sfb_pkg::PARAM_LEN, sfb_pkg::PARAM_ID, sfb_pkg::BASIC_BASE};
		end else begin
			hit = 1'b0;
		end
	end

	// table contents are read-only; only the pointer and status accept writes
	assign ro_write = pwrite && (paddr == sfb_pkg::REG_DATA || paddr == sfb_pkg::REG_WORD
	                             || paddr == sfb_pkg::REG_INFO);

	assign pready  = 1'b1;
	assign pslverr = access_ph && (!hit || ro_write);
	assign prdata  = state_r.rdata;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;

		// read data is staged in the setup cycle so the access needs no wait
		if (setup_ph) begin
			state_nxt.rdata = pwrite ? 32'h0000_0000 : rd_mux;
		end

		if (access_ph) begin
			if (pwrite) begin
				if (paddr == sfb_pkg::REG_PTR && pstrb[0]) begin
					state_nxt.ptr = pwdata[7:0];
				end else if (paddr == sfb_pkg::REG_STATUS && pstrb[1]
				             && pwdata[sfb_pkg::ST_DENIED]) begin
					state_nxt.denied = 1'b0;
				end
			end else if (paddr == sfb_pkg::REG_DATA) begin
				state_nxt.ptr = state_r.ptr + 8'h01;
			end
			// a refused write sets the flag after any clear, so it is not lost
			if (ro_write) begin
				state_nxt.denied = 1'b1;
			end
		end

		// byte stream toward the serial side
		case (state_r.st)
			sfb_pkg::SFB_IDLE: begin
				if (xfer_start) begin
					state_nxt.st      = sfb_pkg::SFB_STREAM;
					state_nxt.s_data  = lane_data[4];
					state_nxt.s_ptr   = xfer_addr + 8'h01;
					state_nxt.s_count = 16'h0001;
				end
			end
			sfb_pkg::SFB_STREAM: begin
				if (xfer_end) begin
					state_nxt.st = sfb_pkg::SFB_IDLE;
				end else if (xfer_start) begin
					state_nxt.s_data  = lane_data[4];
					state_nxt.s_ptr   = xfer_addr + 8'h01;
					state_nxt.s_count = 16'h0001;
				end else if (xfer_next) begin
					// contiguous bytes across both sections, one per request
					state_nxt.s_data  = lane_data[4];
					state_nxt.s_ptr   = state_r.s_ptr + 8'h01;
					state_nxt.s_count = state_r.s_count + 16'h0001;
				end
			end
			default: begin
				state_nxt.st = sfb_pkg::SFB_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r.ptr     <= sfb_pkg::RST_PTR;
			state_r.rdata   <= 32'h0000_0000;
			state_r.denied  <= 1'b0;
			state_r.st      <= sfb_pkg::SFB_IDLE;
			state_r.s_ptr   <= 8'h00;
			state_r.s_data  <= 8'h00;
			state_r.s_count <= 16'h0000;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign xfer_data = state_r.s_data;
	assign xfer_busy = (state_r.st == sfb_pkg::SFB_STREAM);

endmodule

`default_nettype wire

// File: testbench/sfb_param_rom_monitor.sv
// sfb_mon: port-level assertions for the discovery parameter rom.
// assumes binding to sfb_param_rom; one clock, async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module sfb_mon #(
	parameter bit DDR_VARIANT = 1'b0
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        xfer_start,
	input wire logic [7:0]  xfer_addr,
	input wire logic        xfer_next,
	input wire logic        xfer_end,
	input wire logic [7:0]  xfer_data,
	input wire logic        xfer_busy
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_go(logic [7:0] a);
		xfer_start && !xfer_end && xfer_addr == a;
	endsequence
	sequence s_step;
		xfer_next && !xfer_start && !xfer_end;
	endsequence
	AST_ID: assert property (s_go(8'h00) |=> xfer_data == 8'hA5)
		else $error("identifier byte wrong");
	AST_LEN: assert property (s_go(8'h01) |=> xfer_data == 8'h88)
		else $error("length byte wrong");
	AST_B00: assert property (s_go(8'h02) |=> xfer_data == 8'hE7)
		else $error("first basic byte wrong");
	AST_RDTYPE: assert property (s_go(8'h04) |=> xfer_data == (DDR_VARIANT ? 8'hBA : 8'hB2))
		else $error("read type byte wrong");
	AST_DENS: assert property (s_go(8'h09) |=> xfer_data == 8'h1F)
		else $error("density top byte wrong");
	AST_QIO: assert property (s_go(8'h0A) ##1 s_step |=> xfer_data == 8'hEB)
		else $error("quad io opcode wrong");
	AST_BUSY: assert property (xfer_start && !xfer_end |=> xfer_busy)
		else $error("stream not busy after start");
	AST_HOLD: assert property (xfer_busy && !xfer_start && !xfer_next |=> $stable(xfer_data))
		else $error("stream byte moved without request");
	AST_INFO: assert property (psel && penable && !pwrite && paddr == 8'h10 |-> prdata == 32'h88A51090)
		else $error("info word wrong");
	AST_DENY: assert property (psel && penable && pwrite && paddr == 8'h04 |-> pslverr)
		else $error("table write not refused");
endmodule
bind sfb_param_rom sfb_mon #(.DDR_VARIANT(DDR_VARIANT)) sfb_mon_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .xfer_start(xfer_start), .xfer_addr(xfer_addr),
	.xfer_next(xfer_next), .xfer_end(xfer_end), .xfer_data(xfer_data), .xfer_busy(xfer_busy));
`default_nettype wire

// File: testbench/sfb_host.sv
// sfb_host: host side of the byte stream port, reading runs of bytes.
// assumes the bench seeds the random generator; requests change after pclk edges.
`timescale 1ns/1ps
`default_nettype none
module sfb_host (
	input  wire logic       pclk,
	output logic            xfer_start,
	output logic      [7:0] xfer_addr,
	output logic            xfer_next,
	output logic            xfer_end
);
	initial begin
		xfer_start = 1'b0;
		xfer_addr = 8'h00;
		xfer_next = 1'b0;
		xfer_end = 1'b0;
	end
	// random stalls between bytes, so the rom must hold its byte meanwhile
	task automatic burst(input logic [7:0] a, input int n);
		@(posedge pclk);
		xfer_start <= 1'b1;
		xfer_addr <= a;
		for (int i = 1; i < n; i++) begin
			@(posedge pclk);
			xfer_start <= 1'b0;
			xfer_addr <= ~a;
			if ($urandom_range(2) == 0) begin
				xfer_next <= 1'b0;
				@(posedge pclk);
			end
			xfer_next <= 1'b1;
		end
		@(posedge pclk);
		xfer_start <= 1'b0;
		xfer_addr <= ~a;
		xfer_next <= 1'b0;
		xfer_end <= 1'b1;
		@(posedge pclk);
		xfer_end <= 1'b0;
	endtask
endmodule
`default_nettype wire

// File: testbench/sfb_param_rom_test.sv
// sfb_param_rom_test: self-checking bench, apb and byte stream against a queue.
// assumes zero-wait apb; a ddr copy shares all inputs and is checked on the stream.
`timescale 1ns/1ps
`default_nettype none
module sfb_param_rom_test;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        xfer_start;
	logic [7:0]  xfer_addr;
	logic        xfer_next;
	logic        xfer_end;
	logic [7:0]  xfer_data;
	logic [7:0]  xfer_data_ddr;
	logic        xfer_busy;
	logic [7:0]  exd_q[$];
	logic        take_d = 1'b0;
	logic [7:0]  p;
	logic [32:0] exp_q[$];
	logic [32:0] msk_q[$];
	int          err_total = 0;
	int          n_checks = 0;
	always #5 pclk = ~pclk;
	sfb_param_rom #(.DDR_VARIANT(1'b0)) sfb_param_rom_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.xfer_start(xfer_start), .xfer_addr(xfer_addr), .xfer_next(xfer_next),
		.xfer_end(xfer_end), .xfer_data(xfer_data), .xfer_busy(xfer_busy));
	sfb_param_rom #(.DDR_VARIANT(1'b1)) sfb_param_rom_ddr_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(), .pready(), .pslverr(),
		.xfer_start(xfer_start), .xfer_addr(xfer_addr), .xfer_next(xfer_next),
		.xfer_end(xfer_end), .xfer_data(xfer_data_ddr), .xfer_busy());
	sfb_host sfb_host_i (.pclk(pclk), .xfer_start(xfer_start), .xfer_addr(xfer_addr),
		.xfer_next(xfer_next), .xfer_end(xfer_end));
	// ----
	// expected table and checking
	// ----
	function automatic logic [7:0] eb(input logic [7:0] i, input bit ddr = 1'b0);
		case (i)
			8'h00: return 8'hA5;
			8'h01: return 8'h88;
			8'h02: return 8'hE7;
			8'h04: return ddr ? 8'hBA : 8'hB2;
			8'h09: return 8'h1F;
			8'h0A: return 8'h48;
			8'h0B: return 8'hEB;
			default: return 8'hFF;
		endcase
	endfunction
	task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [32:0] e, input logic [32:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
	task automatic burst(input logic [7:0] a, input int n);
		for (int i = 0; i < n; i++) begin
			exp_q.push_back({25'h0, eb(8'(a + i))});
			exd_q.push_back(eb(8'(a + i), 1'b1));
			msk_q.push_back(33'h0FF);
		end
		sfb_host_i.burst(a, n);
	endtask
	always @(posedge pclk) begin
		if (presetn && psel && penable && pready) begin
			check("apb", {pslverr, prdata} & msk_q.pop_front(), exp_q.pop_front());
		end
		if (take_d) begin
			check("stream", {25'h0, xfer_data} & msk_q.pop_front(), exp_q.pop_front());
			check("stream ddr", {25'h0, xfer_data_ddr}, {25'h0, exd_q.pop_front()});
		end
		take_d <= presetn && (xfer_start || (xfer_next && xfer_busy)) && !(xfer_end && xfer_busy);
	end
	initial begin
		#100000;
		err_total++;
		stop_test();
	end
	initial begin
		void'($urandom(94390));
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h00, 32'h0, 4'h0, 33'h0, '1);
		apb(1'b0, 8'h10, 32'h0, 4'h0, {1'b0, 32'h88A51090}, '1);
		burst(8'h00, 14);
		burst(8'h01, 1);
		burst(8'h02, 1);
		burst(8'h04, 1);
		burst(8'h09, 1);
		burst(8'h0A, 1);
		burst(8'h02, 2);
		burst(8'h04, 2);
		burst(8'h09, 2);
		burst(8'h0A, 2);
		repeat (4) burst(8'($urandom_range(15)), $urandom_range(1, 6));
		p = 8'($urandom_range(13));
		apb(1'b1, 8'h00, {24'h0, p}, 4'h1, 33'h0, '1);
		for (int k = 0; k < 4; k++) apb(1'b0, 8'h04, 32'h0, 4'h0, {25'h0, eb(8'(p + k))}, '1);
		apb(1'b0, 8'h08, 32'h0, 4'h0,
			{1'b0, eb(8'(p + 7)), eb(8'(p + 6)), eb(8'(p + 5)), eb(8'(p + 4))}, '1);
		apb(1'b0, 8'h04, 32'h0, 4'h0, {25'h0, eb(8'(p + 4))}, '1);
		apb(1'b1, 8'h04, 32'h12345678, 4'hF, {1'b1, 32'h0}, '1);
		apb(1'b0, 8'h0C, 32'h0, 4'h0, {24'h0, 1'b1, 8'(p + 5)}, 33'h1_00001FFF);
		apb(1'b1, 8'h0C, 32'h100, 4'h2, 33'h0, '1);
		apb(1'b0, 8'h0C, 32'h0, 4'h0, {25'h0, 8'(p + 5)}, 33'h1_00001FFF);
		// last byte of the parameter is index 01h + 88h, the next parameter starts one later
		apb(1'b1, 8'h00, 32'h89, 4'h1, 33'h0, '1);
		apb(1'b0, 8'h0C, 32'h0, 4'h0, {1'b0, 32'h0000_0289}, 33'h1_00001FFF);
		apb(1'b1, 8'h00, 32'h8A, 4'h1, 33'h0, '1);
		apb(1'b0, 8'h0C, 32'h0, 4'h0, {1'b0, 32'h0000_068A}, 33'h1_00001FFF);
		apb(1'b0, 8'h20, 32'h0, 4'h0, {1'b1, 32'h0}, '1);
		// mid-run reset: pointer, flag and stream count all return to zero
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h0C, 32'h0, 4'h0, 33'h0, '1);
		repeat (3) @(posedge pclk);
		if (exp_q.size() != 0 || exd_q.size() != 0) err_total++;
		stop_test();
	end
endmodule
`default_nettype wire
